/* File: include/rfsw_pkg.sv */
// Shared constants and types of the RF switch driver control logic
package rfsw_pkg;

    // Frame layout
    localparam int          FRAME_BITS   = 16;
    localparam int          CNT_W        = 5;
    localparam logic [4:0]  FRAME_FULL   = 5'h10;
    localparam logic [4:0]  CNT_FIRST    = 5'h01;
    localparam int          REG_W        = 8;
    localparam int          PATH_W       = 4;

    // Control register field positions
    localparam int          WR_EN_BIT    = 7;
    localparam int          FAULT_BIT    = 6;
    localparam int          SLEEP_BIT    = 5;
    localparam int          SHDN_DIS_BIT = 4;
    localparam int          HV_DIS_BIT   = 3;
    localparam int          PUMP_BIT     = 1;

    // Frame word bit of the write enable
    localparam int          FRAME_WE_BIT = 15;

    // Values after reset
    localparam logic [7:0]  STATE_RST    = 8'h00;
    localparam logic [7:0]  CTRL_RST     = 8'h00;

    // Synchroniser: selects idle high, everything else idles low
    localparam int          SYNC_W       = 10;
    localparam logic [9:0]  SYNC_RST     = 10'h001;

    // Frame tracking states, one-hot
    typedef enum logic [2:0] {
        FR_IDLE   = 3'h1,
        FR_ACTIVE = 3'h2,
        FR_COMMIT = 3'h4
    } rfsw_frame_t;

endpackage

/* File: design/rfsw_sync2.sv */
// Two-flop synchroniser bank for pins entering the reference clock domain
`timescale 1ns/100ps
module rfsw_sync2 #(
    parameter int                    WIDTH   = 1,
    parameter logic [WIDTH-1:0]      RST_VAL = '0
) (
    input  wire logic                ref_clk_i,
    input  wire logic                resetn_i,
    input  wire logic [WIDTH-1:0]    async_i,
    output logic      [WIDTH-1:0]    sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // First stage feeds only the second stage
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;

endmodule

/* File: design/rfsw_link_shifter.sv */
// Serial-clock domain shifter: receive word, transmit word, frame marker
`timescale 1ns/100ps
module rfsw_link_shifter (
    input  wire logic        sck_i,
    input  wire logic        resetn_i,
    input  wire logic        select_n_i,
    input  wire logic        mosi_i,
    input  wire logic [15:0] load_word_i,
    output logic      [15:0] rx_word_o,
    output logic             rx_full_o,
    output logic             frame_tog_o,
    output logic             miso_o
);

    logic        link_rst_n;
    logic        in_frame_reg;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [15:0] rx_reg;
    logic [15:0] rx_next;
    logic        tog_reg;
    logic        tog_next;
    logic        started_reg;
    logic [15:0] tx_reg;
    logic [15:0] tx_next;
    logic [15:0] tx_base;

    // Frame-scoped state is cleared whenever the select is released
    assign link_rst_n = resetn_i & ~select_n_i;

    // Rising edge: sample data, count bits, mark a new frame
    always_comb begin
        rx_next  = {rx_reg[14:0], mosi_i};                                    // see RULE8
        tog_next = in_frame_reg ? tog_reg : ~tog_reg;
        if (!in_frame_reg) begin
            cnt_next = rfsw_pkg::CNT_FIRST;
        end else if (cnt_reg == rfsw_pkg::FRAME_FULL) begin
            cnt_next = cnt_reg;
        end else begin
            cnt_next = cnt_reg + rfsw_pkg::CNT_FIRST;
        end
    end

    always_ff @(posedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            in_frame_reg <= 1'b0;
        end else begin
            in_frame_reg <= 1'b1;
        end
    end

    // Held across the select release so the other domain can read them
    always_ff @(posedge sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= '0;
            rx_reg  <= '0;
            tog_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rx_reg  <= rx_next;
            tog_reg <= tog_next;
        end
    end

    // Falling edge: first shift starts from the register word, later ones
    // push received bits on so chained parts see the previous word
    always_comb begin
        tx_base = started_reg ? tx_reg : load_word_i;
        tx_next = {tx_base[14:0], rx_reg[0]};                                 // see RULE9 see RULE10
    end

    always_ff @(negedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    always_ff @(negedge sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end

    // Before any falling edge the register MSB is already on the line
    assign miso_o      = started_reg ? tx_reg[15] : load_word_i[15];         // see RULE7
    assign rx_word_o   = rx_reg;
    assign rx_full_o   = (cnt_reg == rfsw_pkg::FRAME_FULL);                  // see RULE26
    assign frame_tog_o = tog_reg;

    // Guarded until an earlier edge exists to look back to
    rx_shift_a: assert property (@(posedge sck_i) disable iff (!resetn_i)  // see RULE8
        cnt_reg != 5'h00 |-> rx_reg[15:1] == $past(rx_reg[14:0]))
        else $error("receive shift register did not shift");

    tx_shift_a: assert property (@(negedge sck_i) disable iff (!link_rst_n) // see RULE9
        $past(started_reg) |-> tx_reg[15:1] == $past(tx_reg[14:0]))
        else $error("transmit shift register did not shift on falling edge");

endmodule

/* File: design/rfsw_driver_ctrl.sv */
// Top of the RF switch driver control logic: serial target, registers, fault handling
//
// Behaviour
// RULE1: Mode pin low selects the serial port, high selects parallel path control.
// RULE2: Parallel mode: pump pin high runs pump; serial mode ignores the pin.
// RULE3: Parallel mode: data-in pin is path control two, clock pin path control one.
// RULE4: Serial pins idle low except select, idle high serially, low as control four.
// RULE5: Host clocks at most 33 MHz; any slower clock with setup and hold works.
// RULE6: Frames are 16 bits MSB first: write enable, 7 control, 8 switch state.
// RULE7: Select falling puts the output word MSB on the data output immediately.
// RULE8: Input data sampled on rising clock; host holds clock idle while deselected.
// RULE9: Each later output bit is shifted out on the falling clock edge.
// RULE10: After 16 bits the previous word is shifted out while new data arrives.
// RULE11: Select rising copies the received word into registers only if write enable.
// RULE12: Two 8-bit read/write registers, read by clocking with select low.
// RULE13: Serial mode takes pump enable and shutdown mode from the control register.
// RULE14: Reset clears both registers to zero.
// RULE15: State bits 3..0 close paths four..one; host writes bits 7..4 as zero.
// RULE16: Control bit 7 low makes the transfer read-only, registers unchanged.
// RULE17: Control bit 6 reports a fault and stays set until written zero.
// RULE18: Control bit 5 high puts analog circuits to sleep.
// RULE19: Control bit 4 high disables fault shutdown, low enables it.
// RULE20: Control bit 3 high disables the high-voltage undervoltage monitor.
// RULE21: Control bit 1 enables the charge pump; bits 2 and 0 do nothing.
// RULE22: After a shutdown the host toggles pump enable low then high to restart.
// RULE23: Shutdown on fault forces all path outputs low and stops the pump.
// RULE24: Parallel mode: each path control input high enables its own path.
// RULE25: Supply or high-voltage undervoltage pulls fault output low and sets the flag.
// RULE26: A frame shorter than 16 clock edges leaves the registers unchanged.
// RULE27: Data output is released whenever the select is high.
`timescale 1ns/100ps
module rfsw_driver_ctrl (
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       mode_i,
    input  wire logic       select_n_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    input  wire logic       pump_enable_pin_i,
    input  wire logic       shutdown_disable_pin_i,
    input  wire logic       vdd_fault_i,
    input  wire logic       hv_fault_i,
    output logic            fault_out_n_o,
    output logic            fault_out_n_oe_o,
    output logic [3:0]      path_o,
    output logic            pump_on_o,
    output logic            sleep_o,
    output logic            hv_monitor_disable_o
);

    // Synchronised pin levels
    logic [9:0]  sync_in;
    logic [9:0]  sync_out;
    logic        sel_n_s;
    logic        mode_s;
    logic        sck_s;
    logic        mosi_s;
    logic        miso_s;
    logic        pump_pin_s;
    logic        shdn_pin_s;
    logic        vdd_flt_s;
    logic        hv_flt_s;
    logic        tog_s;

    // Link side results
    logic [15:0] rx_word;
    logic        rx_full;
    logic        frame_tog;
    logic        link_miso;

    // Registers
    logic [7:0]  state_reg;
    logic [7:0]  state_next;
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic        seen_tog_reg;
    logic        seen_tog_next;
    rfsw_pkg::rfsw_frame_t fr_reg;
    rfsw_pkg::rfsw_frame_t fr_next;
    logic        write_ok;

    // Fault and pump control
    logic        shdn_reg;
    logic        shdn_next;
    logic        pump_req;
    logic        shdn_enabled;
    logic        hv_watch;
    logic        fault_level;

    // Output flops
    logic [3:0]  path_reg;
    logic [3:0]  path_next;
    logic        pump_on_reg;
    logic        pump_on_next;
    logic        sleep_reg;
    logic        sleep_next;
    logic        hv_dis_reg;
    logic        hv_dis_next;
    logic        flt_oe_reg;
    logic        flt_oe_next;

    // Decode helpers
    function automatic logic frame_writes(input logic [15:0] word, input logic full);
        frame_writes = full & word[rfsw_pkg::FRAME_WE_BIT];
    endfunction

    assign sync_in = {frame_tog, hv_fault_i, vdd_fault_i, shutdown_disable_pin_i,
                      pump_enable_pin_i, miso_i, mosi_i, sck_i, mode_i, select_n_i};

    rfsw_sync2 #(
        .WIDTH   (rfsw_pkg::SYNC_W),
        .RST_VAL (rfsw_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (sync_in),
        .sync_o    (sync_out)
    );

    assign sel_n_s    = sync_out[0];
    assign mode_s     = sync_out[1];
    assign sck_s      = sync_out[2];
    assign mosi_s     = sync_out[3];
    assign miso_s     = sync_out[4];
    assign pump_pin_s = sync_out[5];
    assign shdn_pin_s = sync_out[6];
    assign vdd_flt_s  = sync_out[7];
    assign hv_flt_s   = sync_out[8];
    assign tog_s      = sync_out[9];

    rfsw_link_shifter u_link (
        .sck_i       (sck_i),
        .resetn_i    (resetn_i),
        .select_n_i  (select_n_i),
        .mosi_i      (mosi_i),
        .load_word_i ({ctrl_reg, state_reg}),                                  // see RULE6 see RULE12
        .rx_word_o   (rx_word),
        .rx_full_o   (rx_full),
        .frame_tog_o (frame_tog),
        .miso_o      (link_miso)
    );

    // The line is a plain input in parallel mode and shared when deselected;
    // these two follow the pins combinationally so no clock is needed to let go
    assign miso_o    = link_miso;                                            // see RULE7
    assign miso_oe_o = ~mode_i & ~select_n_i;                                // see RULE27 see RULE1

    // Frame tracking. The received word is only read after the synchronised
    // select has risen, when the serial clock is held idle, so it is stable.
    always_comb begin
        fr_next       = fr_reg;
        seen_tog_next = seen_tog_reg;
        write_ok      = 1'b0;
        case (fr_reg)
            rfsw_pkg::FR_IDLE: begin
                if (!sel_n_s) begin
                    fr_next = rfsw_pkg::FR_ACTIVE;
                end
            end
            rfsw_pkg::FR_ACTIVE: begin
                if (sel_n_s) begin
                    fr_next = rfsw_pkg::FR_COMMIT;                           // see RULE11
                end
            end
            rfsw_pkg::FR_COMMIT: begin
                // A frame without any clock leaves the marker untouched
                write_ok      = ~mode_s & (tog_s != seen_tog_reg)
                                & frame_writes(rx_word, rx_full);            // see RULE16 see RULE26
                seen_tog_next = tog_s;
                fr_next       = rfsw_pkg::FR_IDLE;
            end
            default: begin
                fr_next = rfsw_pkg::FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fr_reg       <= rfsw_pkg::FR_IDLE;
            seen_tog_reg <= 1'b0;
        end else begin
            fr_reg       <= fr_next;
            seen_tog_reg <= seen_tog_next;
        end
    end

    // Fault sources; the high-voltage monitor is off in serial mode when disabled by bit or,
    // in parallel mode, when the pump pin is low
    always_comb begin
        hv_watch     = mode_s ? pump_pin_s : ~ctrl_reg[rfsw_pkg::HV_DIS_BIT];  // see RULE20
        fault_level  = vdd_flt_s | (hv_flt_s & hv_watch);                       // see RULE25
        shdn_enabled = mode_s ? ~shdn_pin_s : ~ctrl_reg[rfsw_pkg::SHDN_DIS_BIT]; // see RULE19 see RULE13
        pump_req     = mode_s ? pump_pin_s : ctrl_reg[rfsw_pkg::PUMP_BIT];       // see RULE2 see RULE21
    end

    // Register file. The fault flag set wins over a clearing write in the same
    // cycle; writing 1 does not set it, only hardware can.
    always_comb begin
        state_next = state_reg;
        ctrl_next  = ctrl_reg;
        if (write_ok) begin
            state_next = rx_word[7:0];                                       // see RULE11 see RULE15
            ctrl_next  = rx_word[15:8];
            ctrl_next[rfsw_pkg::FAULT_BIT] = ctrl_reg[rfsw_pkg::FAULT_BIT]
                                             & rx_word[8 + rfsw_pkg::FAULT_BIT]; // see RULE17
        end
        if (fault_level) begin
            ctrl_next[rfsw_pkg::FAULT_BIT] = 1'b1;                           // see RULE25 see RULE17
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= rfsw_pkg::STATE_RST;                                // see RULE14
            ctrl_reg  <= rfsw_pkg::CTRL_RST;
        end else begin
            state_reg <= state_next;
            ctrl_reg  <= ctrl_next;
        end
    end

    // Shutdown latch: armed by a fault while shutdown is enabled, released
    // only while the pump request is low, so the host must toggle it
    always_comb begin
        shdn_next = shdn_reg;
        if (fault_level && shdn_enabled) begin
            shdn_next = 1'b1;                                                // see RULE23
        end else if (!pump_req) begin
            shdn_next = 1'b0;                                                // see RULE22
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shdn_reg <= 1'b0;
        end else begin
            shdn_reg <= shdn_next;
        end
    end

    // Outputs. Parallel path controls come from the serial pins: clock is
    // path one, data in two, data out three, select four.
    always_comb begin
        if (mode_s) begin
            path_next = {sel_n_s, miso_s, mosi_s, sck_s};                    // see RULE3 see RULE24 see RULE4
        end else begin
            path_next = state_reg[3:0];                                      // see RULE15 see RULE1
        end
        sleep_next = ~mode_s & ctrl_reg[rfsw_pkg::SLEEP_BIT];                // see RULE18
        if (shdn_reg) begin
            path_next = '0;                                                  // see RULE23
        end
        pump_on_next = pump_req & ~shdn_reg & ~sleep_next;                   // see RULE23 see RULE18
        hv_dis_next  = ~hv_watch;                                            // see RULE20
        flt_oe_next  = fault_level;                                          // see RULE25
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            path_reg    <= '0;
            pump_on_reg <= 1'b0;
            sleep_reg   <= 1'b0;
            hv_dis_reg  <= 1'b0;
            flt_oe_reg  <= 1'b0;
        end else begin
            path_reg    <= path_next;
            pump_on_reg <= pump_on_next;
            sleep_reg   <= sleep_next;
            hv_dis_reg  <= hv_dis_next;
            flt_oe_reg  <= flt_oe_next;
        end
    end

    assign path_o               = path_reg;
    assign pump_on_o            = pump_on_reg;
    assign sleep_o              = sleep_reg;
    assign hv_monitor_disable_o = hv_dis_reg;
    assign fault_out_n_o        = 1'b0;
    assign fault_out_n_oe_o     = flt_oe_reg;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    parallel_path_a: assert property (                                      // see RULE24
        mode_s && $stable(mode_s) && !shdn_reg
        |=> path_o == {$past(sel_n_s), $past(miso_s), $past(mosi_s), $past(sck_s)})
        else $error("parallel path outputs do not follow control pins");

    serial_pump_a: assert property (                                        // see RULE13
        !mode_s && !shdn_reg && !ctrl_reg[rfsw_pkg::SLEEP_BIT] && $stable(ctrl_reg)
        |=> pump_on_o == $past(ctrl_reg[rfsw_pkg::PUMP_BIT]))
        else $error("serial pump enable does not follow control bit");

    read_only_a: assert property (                                          // see RULE16
        fr_reg == rfsw_pkg::FR_COMMIT && !rx_word[rfsw_pkg::FRAME_WE_BIT]
        |=> $stable(state_reg) && ctrl_reg[7:7] == $past(ctrl_reg[7:7]))
        else $error("read-only frame changed registers");

    short_frame_a: assert property (                                        // see RULE26
        fr_reg == rfsw_pkg::FR_COMMIT && !rx_full |=> $stable(state_reg))
        else $error("short frame changed the state register");

    write_commit_a: assert property (                                       // see RULE11
        fr_reg == rfsw_pkg::FR_COMMIT && write_ok |=> state_reg == $past(rx_word[7:0]))
        else $error("write frame not copied into state register");

    fault_sticky_a: assert property (                                       // see RULE17
        ctrl_reg[rfsw_pkg::FAULT_BIT] && !write_ok |=> ctrl_reg[rfsw_pkg::FAULT_BIT])
        else $error("fault flag dropped without a clearing write");

    fault_report_a: assert property (                                       // see RULE25
        fault_level |=> ctrl_reg[rfsw_pkg::FAULT_BIT] && fault_out_n_oe_o)
        else $error("fault not reported on flag and fault output");

    shutdown_force_a: assert property (                                     // see RULE23
        fault_level && shdn_enabled |=> ##1 path_o == 4'h0 && !pump_on_o)
        else $error("fault shutdown did not clear paths and pump");

    sleep_out_a: assert property (                                          // see RULE18
        !mode_s && $stable(mode_s) |=> sleep_o == $past(ctrl_reg[rfsw_pkg::SLEEP_BIT]))
        else $error("sleep output does not follow control bit");

    restart_toggle_a: assert property (                                     // see RULE22
        shdn_reg && pump_req && !fault_level |=> shdn_reg)
        else $error("shutdown released without pump enable toggle");

    hv_monitor_a: assert property (                                         // see RULE20
        !mode_s |=> hv_monitor_disable_o == $past(ctrl_reg[rfsw_pkg::HV_DIS_BIT]))
        else $error("monitor disable output does not follow control bit");

    fault_clear_a: assert property (                                        // see RULE17
        write_ok && !rx_word[8 + rfsw_pkg::FAULT_BIT] && !fault_level |=> !ctrl_reg[rfsw_pkg::FAULT_BIT])
        else $error("fault flag not cleared by a zero write");

    serial_path_a: assert property (                                        // see RULE15
        !mode_s && !shdn_reg |=> path_o == $past(state_reg[3:0]))
        else $error("serial path outputs do not follow state register");

endmodule

/* File: test/rfsw_host_model.sv */
// Host serial controller model driving the link pins
`timescale 1ns/100ps
module rfsw_host_model (
    output logic      select_n_o,
    output logic      sck_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        select_n_o = 1'b1;
        sck_o      = 1'b0;
        mosi_o     = 1'b0;
    end

    // 32 ns clock period keeps under the rate limit; n bits MSB first
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        #3;
        select_n_o = 1'b0;
        mosi_o = tx[n-1];
        #16;
        for (int i = n - 1; i >= 0; i--) begin
            sck_o = 1'b1;
            rx = {rx[30:0], miso_i};
            #16;
            sck_o = 1'b0;
            // Released data line falls to its pull-down
            mosi_o = (i > 0) ? tx[i-1] : 1'b0;
            #16;
        end
        select_n_o = 1'b1;
        // Long gap so the commit never overlaps the next frame
        #64;
    endtask

    // Parallel mode: the link pins become path controls
    task automatic set_pins(input logic four, input logic two, input logic one);
        select_n_o <= four;
        mosi_o <= two;
        sck_o <= one;
    endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench of the RF switch driver control logic
`timescale 1ns/100ps
module tb;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i;
    logic        mode_i = 1'b0;
    logic        pump_pin = 1'b0, sdis_pin = 1'b0, vdd_f = 1'b0, hv_f = 1'b0, ctl_three = 1'b0;
    logic        select_n, sck, mosi, miso, miso_oe, flt_n, flt_oe, pump_on, sleep, hv_dis;
    logic        miso_pin;
    logic [3:0]  path;
    logic [31:0] rx;
    int          num_errors = 0;
    int          check_count = 0;

    always #4 ref_clk_i = ~ref_clk_i;
    // Pin level: driven by the device, else path control three or pull-down
    assign miso_pin = miso_oe ? miso : (mode_i & ctl_three);

    rfsw_host_model host (.select_n_o(select_n), .sck_o(sck), .mosi_o(mosi), .miso_i(miso_pin));

    rfsw_driver_ctrl dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mode_i(mode_i), .select_n_i(select_n),
        .sck_i(sck), .mosi_i(mosi), .miso_i(miso_pin), .miso_o(miso), .miso_oe_o(miso_oe),
        .pump_enable_pin_i(pump_pin), .shutdown_disable_pin_i(sdis_pin), .vdd_fault_i(vdd_f),
        .hv_fault_i(hv_f), .fault_out_n_o(flt_n), .fault_out_n_oe_o(flt_oe), .path_o(path),
        .pump_on_o(pump_on), .sleep_o(sleep), .hv_monitor_disable_o(hv_dis)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic report_and_stop;
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Commit plus output flop lands within 7 cycles of select rising
    task automatic wr(input logic [15:0] w);
        host.frame({16'h0000, w}, 16, rx);
        settle(8);
    endtask

    task automatic t_reset;
        chk(miso_oe, 1'b0);
        chk({path, pump_on, sleep, hv_dis, flt_oe}, 8'h00);
        wr(16'h0000);
        chk(rx[15:0], 16'h0000);
    endtask

    task automatic t_write;
        wr(16'h8205);
        chk(path, 4'h5);
        chk(pump_on, 1'b1);
        wr(16'h0000);
        chk(rx[15:0], 16'h8205);
        // Leaves ones behind so a short frame would look like a write
        wr(16'h00ff);
        chk(rx[15:0], 16'h8205);
        host.frame(32'h0000_000a, 8, rx);
        settle(8);
        chk(path, 4'h5);
    endtask

    task automatic t_chain;
        host.frame({16'h0055, 16'ha90a}, 32, rx);
        chk(rx, {16'h8205, 16'h0055});
        settle(8);
        chk({sleep, hv_dis, pump_on}, 3'b110);
        chk(path, 4'ha);
    endtask

    task automatic t_fault;
        wr(16'h8203);
        sdis_pin <= 1'b1;
        vdd_f <= 1'b1;
        settle(6);
        chk({flt_n, flt_oe}, 2'b01);
        chk({path, pump_on}, 5'h00);
        vdd_f <= 1'b0;
        settle(6);
        chk(flt_oe, 1'b0);
        wr(16'h0000);
        chk(rx[15:0], 16'hc203);
        // Pump bit low then high restarts after a shutdown
        wr(16'h8003);
        wr(16'h8203);
        chk({path, pump_on}, 5'h07);
        wr(16'h0000);
        chk(rx[15:0], 16'h8203);
        sdis_pin <= 1'b0;
    endtask

    task automatic t_parallel;
        mode_i <= 1'b1;
        host.set_pins(1'b1, 1'b0, 1'b1);
        settle(6);
        chk(path, 4'h9);
        chk({miso_oe, pump_on}, 2'b00);
        pump_pin <= 1'b1;
        ctl_three <= 1'b1;
        host.set_pins(1'b0, 1'b1, 1'b0);
        settle(6);
        chk(path, 4'h6);
        chk(pump_on, 1'b1);
    endtask

    initial begin
        // Falling from unknown gives the link flops a reset edge
        resetn_i <= 1'b0;
        settle(10);
        resetn_i <= 1'b1;
        settle(4);
        t_reset;
        t_write;
        t_chain;
        t_fault;
        t_parallel;
        report_and_stop;
    end

    initial begin
        settle(20000);
        num_errors++;
        report_and_stop;
    end
endmodule
